// ===== verilog/swl_consts.svh
/*
 constants for the serial word load port: word layout and host timing.
 assumes the 25 MHz system clock of both ends.
*/
`ifndef SWL_CONSTS_SVH
`define SWL_CONSTS_SVH

// ----------------------------------------
// word layout
// ----------------------------------------
`define SWL_WORD_BITS 16
`define SWL_CNT_BITS 5
`define SWL_CTRL_MSB 15
`define SWL_CTRL_LSB 12
`define SWL_ADDR_MSB 11
`define SWL_ADDR_LSB 8
`define SWL_DATA_MSB 7
`define SWL_DATA_LSB 0

// ----------------------------------------
// timing
// ----------------------------------------
`define SWL_CLK_MHZ 25
`define SWL_LINK_MAX_MHZ 40
// host shift clock half period in system cycles
`define SWL_HALF_CYCLES 4
`define SWL_GAP_CYCLES 4

`endif

// ===== verilog/swl_pkg.sv
/*
 types shared by both ends of the serial word load port.
 assumes swl_consts.svh is included before use.
*/
`include "swl_consts.svh"

package swl_pkg;

	typedef enum logic [2:0] {
		SWL_IDLE = 3'b000,
		SWL_LEAD = 3'b001,
		SWL_LOW = 3'b010,
		SWL_HIGH = 3'b011,
		SWL_GAP = 3'b100,
		SWL_TAIL = 3'b101
	} swl_host_state_t;

	typedef struct packed {
		logic [1:0] sck_sync;
		logic [1:0] fs_sync;
		logic [1:0] sd_sync;
		logic sck_prev;
		logic [`SWL_CNT_BITS-1:0] count;
		logic [`SWL_WORD_BITS-1:0] shift;
		logic word_valid;
		logic [3:0] word_ctrl;
		logic [3:0] word_addr;
		logic [7:0] word_data;
	} swl_dev_t;

	typedef struct packed {
		swl_host_state_t state;
		logic [3:0] timer;
		logic [`SWL_CNT_BITS-1:0] bit_idx;
		logic [`SWL_WORD_BITS-1:0] word;
		logic byte_mode;
		logic sck;
		logic fs_n;
		logic sd;
		logic busy;
		logic done;
	} swl_host_t;

endpackage

// ===== verilog/swl_link_if.sv
/*
 three wire write-only link between host and device.
 assumes both ends sit on the same bench; wires are plain one way.
*/
`timescale 1ns/1ps

interface swl_link_if;
	logic shift_clk;
	logic frame_sync_n;
	logic serial_data_in;

	modport host (
		output shift_clk,
		output frame_sync_n,
		output serial_data_in
	);

	modport device (
		input shift_clk,
		input frame_sync_n,
		input serial_data_in
	);
endinterface

// ===== verilog/swl_device.sv
/*
 device end: captures one 16-bit word per frame and splits it.
 assumes link pins are asynchronous to clk and slow enough to be sampled by the 25 MHz clk through two flops.
*/
`timescale 1ns/1ps
`include "swl_consts.svh"

// How it works
// (RULE1) frame sync low frames exactly sixteen bits
// (RULE2) sample data on each falling shift edge
// (RULE3) host changes data on rising edges
// (RULE4) shift clock at most forty megahertz; device samples it with the 25 MHz clk, so only far slower clocks are caught
// (RULE5) free running or idling clock both accepted
// (RULE6) words arrive most significant bit first
// (RULE7) word splits control, address, data fields
// (RULE8) byte hosts hold frame across bytes
// (RULE9) active high frame sync inverted by host
// (RULE10) byte hosts rest clock high between bytes
// (RULE11) one frame pulse per sixteen-bit word
// (RULE12) ignore edges outside frame; deliver after sixteenth
module swl_device (
	// system
	input wire logic clk,
	input wire logic rst,
	// link
	swl_link_if.device link,
	// received word
	output logic word_valid,
	output logic [3:0] word_ctrl,
	output logic [3:0] word_addr,
	output logic [7:0] word_data
);

	swl_pkg::swl_dev_t r;
	swl_pkg::swl_dev_t next_r;

	logic fall;
	logic in_frame;

	// ----------------------------------------
	// capture
	// ----------------------------------------
	always_comb begin
		next_r = r;
		next_r.sck_sync = {r.sck_sync[0], link.shift_clk}; // RULE4
		next_r.fs_sync = {r.fs_sync[0], link.frame_sync_n};
		next_r.sd_sync = {r.sd_sync[0], link.serial_data_in};
		next_r.sck_prev = r.sck_sync[1];
		next_r.word_valid = 1'b0;
		// falling edge found on synced clock
		fall = r.sck_prev & ~r.sck_sync[1]; // RULE2 RULE5
		in_frame = ~r.fs_sync[1];
		if (!in_frame) begin
			// edges outside a frame are ignored; counter re-armed
			next_r.count = '0; // RULE12 RULE5
		end else if (fall && r.count < 5'(`SWL_WORD_BITS)) begin
			// msb first shift
			next_r.shift = {r.shift[`SWL_WORD_BITS-2:0], r.sd_sync[1]}; // RULE6 RULE2
			next_r.count = r.count + 5'h01; // RULE1
			if (r.count == 5'(`SWL_WORD_BITS - 1)) begin
				next_r.word_valid = 1'b1; // RULE12 RULE1
				next_r.word_ctrl = next_r.shift[`SWL_CTRL_MSB:`SWL_CTRL_LSB]; // RULE7
				next_r.word_addr = next_r.shift[`SWL_ADDR_MSB:`SWL_ADDR_LSB]; // RULE7
				next_r.word_data = next_r.shift[`SWL_DATA_MSB:`SWL_DATA_LSB]; // RULE7
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '0;
			r.sck_sync <= 2'h3;
			r.fs_sync <= 2'h3;
			r.sck_prev <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign word_valid = r.word_valid;
	assign word_ctrl = r.word_ctrl;
	assign word_addr = r.word_addr;
	assign word_data = r.word_data;

endmodule

// ===== verilog/swl_host.sv
/*
 host end: sends one 16-bit word per request over the three wire link.
 assumes the device samples on falling shift clock edges.
*/
`timescale 1ns/1ps
`include "swl_consts.svh"

module swl_host (
	// system
	input wire logic clk,
	input wire logic rst,
	// request
	input wire logic send,
	input wire logic [15:0] send_word,
	input wire logic send_bytes,
	output logic busy,
	output logic done,
	// link
	swl_link_if.host link
);

	swl_pkg::swl_host_t r;
	swl_pkg::swl_host_t next_r;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		unique case (r.state)
			swl_pkg::SWL_IDLE: begin
				next_r.sck = 1'b1; // RULE10
				next_r.fs_n = 1'b1;
				if (send) begin
					next_r.word = send_word;
					next_r.byte_mode = send_bytes;
					next_r.bit_idx = '0;
					next_r.fs_n = 1'b0; // RULE1 RULE9 RULE11
					next_r.busy = 1'b1;
					next_r.timer = 4'(`SWL_HALF_CYCLES - 1);
					next_r.state = swl_pkg::SWL_LEAD;
				end
			end
			swl_pkg::SWL_LEAD: begin
				if (r.timer == 4'h0) begin
					next_r.sd = r.word[`SWL_WORD_BITS-1]; // RULE6
					next_r.timer = 4'(`SWL_HALF_CYCLES - 1);
					next_r.state = swl_pkg::SWL_HIGH;
				end else begin
					next_r.timer = r.timer - 4'h1;
				end
			end
			swl_pkg::SWL_HIGH: begin
				if (r.timer == 4'h0) begin
					next_r.sck = 1'b0; // RULE4
					next_r.timer = 4'(`SWL_HALF_CYCLES - 1);
					next_r.state = swl_pkg::SWL_LOW;
				end else begin
					next_r.timer = r.timer - 4'h1;
				end
			end
			swl_pkg::SWL_LOW: begin
				if (r.timer == 4'h0) begin
					next_r.sck = 1'b1;
					next_r.bit_idx = r.bit_idx + 5'h01;
					next_r.word = {r.word[`SWL_WORD_BITS-2:0], 1'b0};
					// data changes with the rising edge
					next_r.sd = r.word[`SWL_WORD_BITS-2]; // RULE3
					next_r.timer = 4'(`SWL_HALF_CYCLES - 1);
					if (r.bit_idx == 5'(`SWL_WORD_BITS - 1)) begin
						next_r.state = swl_pkg::SWL_TAIL; // RULE8
					end else if (r.byte_mode && r.bit_idx == 5'h07) begin
						// frame held low, clock resting high
						next_r.timer = 4'(`SWL_GAP_CYCLES - 1);
						next_r.state = swl_pkg::SWL_GAP; // RULE8 RULE10
					end else begin
						next_r.state = swl_pkg::SWL_HIGH;
					end
				end else begin
					next_r.timer = r.timer - 4'h1;
				end
			end
			swl_pkg::SWL_GAP: begin
				if (r.timer == 4'h0) begin
					next_r.timer = 4'(`SWL_HALF_CYCLES - 1);
					next_r.state = swl_pkg::SWL_HIGH;
				end else begin
					next_r.timer = r.timer - 4'h1;
				end
			end
			swl_pkg::SWL_TAIL: begin
				if (r.timer == 4'h0) begin
					next_r.fs_n = 1'b1; // RULE8
					next_r.busy = 1'b0;
					next_r.done = 1'b1;
					next_r.state = swl_pkg::SWL_IDLE;
				end else begin
					next_r.timer = r.timer - 4'h1;
				end
			end
			default: begin
				next_r.state = swl_pkg::SWL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '0;
			r.state <= swl_pkg::SWL_IDLE;
			r.sck <= 1'b1;
			r.fs_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign link.shift_clk = r.sck;
	assign link.frame_sync_n = r.fs_n;
	assign link.serial_data_in = r.sd;
	assign busy = r.busy;
	assign done = r.done;

endmodule

// ===== verification/swl_link_asserts.sv
/*
 checker for the host to device link.
 assumes the bench wires the link, clock, reset and end flags in.
*/
`timescale 1ns/1ps

module swl_link_asserts (
	// system
	input wire logic clk,
	input wire logic rst,
	// link
	input wire logic shift_clk,
	input wire logic frame_sync_n,
	input wire logic serial_data_in,
	// ends
	input wire logic word_valid,
	input wire logic busy,
	input wire logic done
);
	// ----
	// properties
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_frame_hold; $fell(frame_sync_n) |-> !frame_sync_n [*8]; endproperty
	a_frame_hold: assert property (p_frame_hold) else $error("frame too short");
	property p_busy_start; $rose(busy) |-> $fell(frame_sync_n); endproperty
	a_busy_start: assert property (p_busy_start) else $error("frame not opened");
	property p_fall_in; $fell(shift_clk) |-> !frame_sync_n; endproperty
	a_fall_in: assert property (p_fall_in) else $error("fall outside frame");
	property p_rate; $fell(shift_clk) |-> !shift_clk [*4] ##1 shift_clk; endproperty
	a_rate: assert property (p_rate) else $error("shift clock rate");
	property p_data_edge; $changed(serial_data_in) && !frame_sync_n |-> shift_clk; endproperty
	a_data_edge: assert property (p_data_edge) else $error("data moved while low");
	property p_idle; frame_sync_n |-> shift_clk; endproperty
	a_idle: assert property (p_idle) else $error("clock not idle high");
	property p_done_end; done |-> $rose(frame_sync_n) && !busy; endproperty
	a_done_end: assert property (p_done_end) else $error("done without frame end");
	property p_valid; word_valid |-> !frame_sync_n ##1 !word_valid; endproperty
	a_valid: assert property (p_valid) else $error("word valid misplaced");
	cover property (word_valid);
	cover property (done);
	cover property ($fell(frame_sync_n));
endmodule

// ===== verification/tb_serial_word_load_port.sv
/*
 bench: host drives device; a second device is driven by the bench.
 assumes design files and checker are compiled first.
*/
`timescale 1ns/1ps

module tb_serial_word_load_port;
	// ----
	// setup
	// ----
	logic clk = 0, rst = 1, send = 0, send_bytes = 0, busy, done, word_valid, wv2;
	logic [15:0] send_word = 16'h0000, w;
	logic [3:0] word_ctrl, word_addr, c2, a2;
	logic [7:0] word_data, d2;
	logic [15:0] cw [3] = '{16'h0000, 16'hFFFF, 16'h8001};
	int num_errors = 0, n_compared = 0, seed = 61068, vcnt = 0, v2 = 0, k;
	swl_link_if link();
	swl_link_if l2();
	swl_host swl_host_i (.clk(clk), .rst(rst), .send(send), .send_word(send_word), .send_bytes(send_bytes),
		.busy(busy), .done(done), .link(link));
	swl_device swl_device_i (.clk(clk), .rst(rst), .link(link), .word_valid(word_valid), .word_ctrl(word_ctrl),
		.word_addr(word_addr), .word_data(word_data));
	swl_device swl_device_i2 (.clk(clk), .rst(rst), .link(l2), .word_valid(wv2), .word_ctrl(c2),
		.word_addr(a2), .word_data(d2));
	swl_link_asserts swl_link_asserts_i (.clk(clk), .rst(rst), .shift_clk(link.shift_clk),
		.frame_sync_n(link.frame_sync_n), .serial_data_in(link.serial_data_in), .word_valid(word_valid),
		.busy(busy), .done(done));
	initial forever #20 clk = ~clk;
	always @(negedge clk) begin
		vcnt += (word_valid === 1'b1);
		v2 += (wv2 === 1'b1);
	end
	// ----
	// tasks
	// ----
	function logic [15:0] fields(input logic [15:0] x);
		return {x[15:12], x[11:8], x[7:0]};
	endfunction
	task summarize;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task xfer(input logic [15:0] x, input logic b);
		vcnt = 0;
		@(posedge clk) #1 send = 1;
		send_word = x;
		send_bytes = b;
		@(posedge clk) #1 send_word = ~x;
		@(posedge clk) #1 send = 0;
		for (k = 0; k < 400 && done !== 1'b1; k++) begin
			@(posedge clk) #1;
		end
		if (k == 400) begin
			num_errors++;
			summarize();
		end else begin
			chk({word_ctrl, word_addr, word_data}, fields(x));
			chk(16'(vcnt), 16'h0001);
		end
	endtask
	task bitc(input logic b);
		l2.serial_data_in = b;
		l2.shift_clk = 1;
		#160 l2.shift_clk = 0;
		#160;
	endtask
	task frame2(input logic [15:0] x, input int n);
		l2.frame_sync_n = 0;
		for (int i = 0; i < n; i++) bitc(x[15 - (i % 16)]);
		#160 l2.frame_sync_n = 1;
		l2.serial_data_in = ~l2.serial_data_in;
		#320;
	endtask
	// ----
	// main
	// ----
	initial begin
		l2.shift_clk = 1;
		l2.frame_sync_n = 1;
		l2.serial_data_in = 0;
		repeat (12) @(posedge clk);
		#1 rst = 0;
		for (int j = 0; j < 6; j++) xfer(cw[j >> 1], j[0]);
		repeat (12) begin
			w = 16'($random(seed));
			xfer(w, 1'($random(seed)));
		end
		#13 repeat (6) bitc(1'($random(seed)));
		frame2(16'hA5C3, 8);
		chk(16'(v2), 16'h0000);
		frame2(16'h3C5A, 17);
		#400 chk(16'(v2), 16'h0001);
		chk({c2, a2, d2}, fields(16'h3C5A));
		summarize();
	end
endmodule
